// *** design/plw_cnt_if.sv ***
// interface between the watchdog control and its counter
`timescale 1ns/1ps
interface plw_cnt_if #(
  parameter int CNT_W = 21
);
  logic             tick;
  logic             clear;
  logic [4:0]       exp;
  logic             ovf;
  logic [CNT_W-1:0] count;

  modport ctl (output tick, output clear, output exp, input ovf, input count);
  modport cnt (input tick, input clear, input exp, output ovf, output count);
endinterface : plw_cnt_if

// *** design/plw_counter.sv ***
// watchdog up-counter with selectable power-of-two overflow
`timescale 1ns/1ps
module plw_counter #(
  parameter int CNT_W = 21
) (
  // clock and control
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // control side
  plw_cnt_if.cnt    cnt
);
  localparam logic [CNT_W:0] ONE = (CNT_W+1)'(1);

  logic [CNT_W-1:0] count_q;
  wire  [CNT_W:0]   limit = ONE << cnt.exp;
  wire  [CNT_W-1:0] last  = CNT_W'(limit - ONE);
  wire              hit   = cnt.tick & (count_q == last);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else if (ce_i) begin
      if (cnt.clear || hit) begin
        count_q <= '0;
      end else if (cnt.tick) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // gated ticks leave the value held, so counting resumes from it  [R21]
  assign cnt.ovf   = ce_i & hit & ~cnt.clear;
  assign cnt.count = count_q;
endmodule : plw_counter

// *** design/plw_pkg.sv ***
// constants and types shared by the program loop watchdog
package plw_pkg;

  // register map
  localparam logic [15:0] PLW_MODE_ADDR     = 16'hFF98;
  localparam logic [15:0] PLW_REFRESH_ADDR  = 16'hFF99;

  // reset and fixed values
  localparam logic [7:0]  PLW_MODE_RST      = 8'h67;
  localparam logic [7:0]  PLW_REFRESH_READ  = 8'h9A;
  localparam logic [7:0]  PLW_REFRESH_KEY   = 8'hAC;
  localparam logic [7:0]  PLW_UNMAPPED_READ = 8'h00;
  localparam logic [2:0]  PLW_MODE_TOP      = 3'h3;

  // field positions in the mode register
  localparam int          PLW_CSEL_HI_BIT   = 4;
  localparam int          PLW_CSEL_LO_BIT   = 3;
  localparam int          PLW_PSEL_MSB      = 2;
  localparam int          PLW_PSEL_LSB      = 0;
  localparam logic [1:0]  PLW_CSEL_SLOW     = 2'h0;
  localparam logic [1:0]  PLW_CSEL_MAIN     = 2'h1;

  // reset cause register position of the watchdog flag
  localparam int          PLW_CAUSE_WDT_BIT = 4;

  // overflow exponents: period code k gives 2^(base+k) source cycles
  localparam logic [4:0]  PLW_SLOW_EXP_BASE = 5'h0B;
  localparam logic [4:0]  PLW_MAIN_EXP_BASE = 5'h0D;
  localparam int          PLW_EXP_W         = 5;

  // mode register write phase
  typedef enum logic [2:0] {
    PLW_ST_OPEN    = 3'b001,
    PLW_ST_LOCKED  = 3'b010,
    PLW_ST_STOPPED = 3'b100
  } plw_state_t;

endpackage : plw_pkg

// *** design/plw_sync3.sv ***
// three-stage synchroniser with rising edge pulse for an oscillator pin
`timescale 1ns/1ps
module plw_sync3 (
  // clock and control
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // pin and edge
  input  wire logic pin_i,
  output logic      rise_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  wire  agree = (s2_q == s3_q);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else if (ce_i) begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      if (agree) begin
        level_q <= s3_q;
      end
    end
  end

  // a change counts only once stages two and three agree
  assign rise_o = ce_i & agree & s3_q & ~level_q;
endmodule : plw_sync3

// *** design/plw_top.sv ***
// program loop watchdog: mode and refresh registers, clock select, gating, reset
// Notes on behaviour
// R01: counter overflow without refresh asserts the internal system reset.
// R02: a watchdog reset sets bit 4 of the reset cause register.
// R03: fixed option: always counts from the slow oscillator, cannot be stopped.
// R04: selectable option: main, slow or stopped; slow after reset release.
// R05: after reset, count from slow oscillator with period code all ones.
// R06: mode register writable once; a second write asserts reset.
// R07: software writes the top three mode bits as 0,1,1.
// R08: clock select 00 slow, 01 main, 1x stopped.
// R09: fixed option ignores clock select writes; slow oscillator remains.
// R10: code k overflows after 2^(11+k) slow or 2^(13+k) main cycles.
// R11: software sets the mode register only by whole byte writes.
// R12: every mode register write inserts one wait cycle.
// R13: writing the key to the refresh register clears the counter.
// R14: writing any other value to the refresh register asserts reset.
// R15: a bit operation on the refresh register asserts reset.
// R16: the refresh register always reads 9A.
// R17: main clock source is gated while stopped, halted or stabilising.
// R18: slow source gated in halt/stop, or when stopped with cpu on main.
// R19: each accepted mode write clears the counter at once.
// R20: once stopped, misuse of either register causes no reset.
// R21: while gated the counter holds its value and resumes from it.
// R22: counter is wide enough for the longest overflow of either source.
`timescale 1ns/1ps
module plw_top
  import plw_pkg::*;
#(
  parameter int CNT_W = 21
) (
  // clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // power-on option: high fixes the slow oscillator
  input  wire logic        opt_slow_fixed_i,
  // cpu register port
  input  wire logic [15:0] bus_addr_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  input  wire logic        bus_bitop_i,
  input  wire logic [7:0]  bus_wdata_i,
  output logic      [7:0]  bus_rdata_o,
  output logic             bus_wait_o,
  // oscillator pins
  input  wire logic        slow_osc_frequency_i,
  input  wire logic        main_osc_input_i,
  // power and clock status
  input  wire logic        halt_i,
  input  wire logic        stop_i,
  input  wire logic        main_osc_stopped_i,
  input  wire logic        osc_stab_i,
  input  wire logic        cpu_on_main_i,
  input  wire logic        slow_osc_stopped_i,
  // reset cause
  input  wire logic        cause_clr_i,
  output logic             watchdog_reset_cause_flag_o,
  output logic             wdt_reset_o
);

  // state
  plw_state_t state_q;
  plw_state_t state_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic       fixed_q;
  logic       strap_pend_q;
  logic       reset_q;
  logic       cause_q;
  logic       wait_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // oscillator edges
  logic [1:0] osc_pin;
  logic [1:0] osc_rise;

  assign osc_pin = {main_osc_input_i, slow_osc_frequency_i};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_osc
      plw_sync3 u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .pin_i      (osc_pin[g]),
        .rise_o     (osc_rise[g])
      );
    end
  endgenerate

  wire slow_edge = osc_rise[0];
  wire main_edge = osc_rise[1];

  // counter
  plw_cnt_if #(.CNT_W(CNT_W)) cnt_b ();

  plw_counter #(.CNT_W(CNT_W)) u_cnt (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .cnt        (cnt_b.cnt)
  );

  // address decode
  wire mode_hit    = (bus_addr_i == PLW_MODE_ADDR);
  wire refresh_hit = (bus_addr_i == PLW_REFRESH_ADDR);
  wire mode_wr     = bus_wr_i & mode_hit;
  wire refresh_wr  = bus_wr_i & refresh_hit;

  // write phase
  wire is_open    = (state_q == PLW_ST_OPEN);
  wire is_locked  = (state_q == PLW_ST_LOCKED);
  wire is_stopped = (state_q == PLW_ST_STOPPED);
  wire first_wr   = mode_wr & is_open;

  // fixed option forces the top bits and the slow source  [R09] [R07]
  wire [7:0] wr_val = fixed_q ?
                      {PLW_MODE_TOP, PLW_CSEL_SLOW, bus_wdata_i[PLW_PSEL_MSB:PLW_PSEL_LSB]} :
                      bus_wdata_i;

  // clock select decode; the upper bit alone stops the watchdog  [R08]
  wire [1:0] csel     = mode_q[PLW_CSEL_HI_BIT:PLW_CSEL_LO_BIT];
  wire [2:0] psel     = mode_q[PLW_PSEL_MSB:PLW_PSEL_LSB];
  wire       sel_slow = (csel == PLW_CSEL_SLOW);
  wire       sel_main = (csel == PLW_CSEL_MAIN);
  wire       stop_req = wr_val[PLW_CSEL_HI_BIT] & ~fixed_q; // [R03]

  // misuse detection; none of it counts once stopped  [R20]
  wire key_ok       = (bus_wdata_i == PLW_REFRESH_KEY);
  wire second_wr    = mode_wr & is_locked; // [R06]
  wire bad_value    = refresh_wr & ~bus_bitop_i & ~key_ok; // [R14]
  wire bad_bitop    = refresh_wr & bus_bitop_i; // [R15]
  wire misuse       = (second_wr | bad_value | bad_bitop) & ~is_stopped;
  wire good_refresh = refresh_wr & ~bus_bitop_i & key_ok; // [R13]
  wire trip         = misuse | cnt_b.ovf; // [R01]

  // clock gating; in the fixed option nothing stops the count  [R03]
  wire gate_main = sel_main & (halt_i | stop_i | main_osc_stopped_i | osc_stab_i); // [R17]
  wire gate_slow = sel_slow & (halt_i | stop_i | (cpu_on_main_i & slow_osc_stopped_i)); // [R18]
  wire gated     = ~fixed_q & (gate_main | gate_slow);

  // source pick and overflow exponent  [R10]
  wire src_edge = sel_main ? main_edge : (sel_slow & slow_edge);
  wire [4:0] exp_base = sel_main ? PLW_MAIN_EXP_BASE : PLW_SLOW_EXP_BASE;

  assign cnt_b.tick  = src_edge & ~gated & ~is_stopped;
  assign cnt_b.exp   = exp_base + {2'b00, psel};
  // misuse restarts the count; an overflow clears itself, so ovf never feeds back into clear
  assign cnt_b.clear = first_wr | good_refresh | misuse; // [R19] [R13]

  // next mode and phase
  always_comb begin
    state_d = state_q;
    mode_d  = mode_q;
    if (trip) begin
      // watchdog reset returns the block to its reset state  [R05]
      state_d = PLW_ST_OPEN;
      mode_d  = PLW_MODE_RST;
    end else if (first_wr) begin
      mode_d = wr_val;
      if (stop_req) begin
        state_d = PLW_ST_STOPPED;
      end else begin
        state_d = PLW_ST_LOCKED;
      end
    end
  end

  // read data: refresh register never returns what was written  [R16]
  always_comb begin
    if (mode_hit) begin
      rdata_d = mode_q;
    end else if (refresh_hit) begin
      rdata_d = PLW_REFRESH_READ;
    end else begin
      rdata_d = PLW_UNMAPPED_READ;
    end
  end

  // mode register and write phase; slow source, longest period at reset  [R04] [R05]
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q <= PLW_ST_OPEN;
      mode_q  <= PLW_MODE_RST;
    end else if (ce_i) begin
      state_q <= state_d;
      mode_q  <= mode_d;
    end
  end

  // option strap caught on the first enabled edge after release
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fixed_q      <= 1'b1;
      strap_pend_q <= 1'b1;
    end else if (ce_i && strap_pend_q) begin
      fixed_q      <= opt_slow_fixed_i;
      strap_pend_q <= 1'b0;
    end
  end

  // internal reset pulse
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reset_q <= 1'b0;
    end else if (ce_i) begin
      reset_q <= trip; // [R01] [R06] [R14] [R15]
    end
  end

  // reset cause flag survives the watchdog reset; a new event beats a clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cause_q <= 1'b0;
    end else if (ce_i) begin
      cause_q <= trip | (cause_q & ~cause_clr_i); // [R02]
    end
  end

  // bus answers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wait_q  <= 1'b0;
      rdata_q <= PLW_UNMAPPED_READ;
    end else if (ce_i) begin
      wait_q <= mode_wr; // [R12]
      if (bus_rd_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign bus_rdata_o                 = rdata_q;
  assign bus_wait_o                  = wait_q;
  assign wdt_reset_o                 = reset_q;
  assign watchdog_reset_cause_flag_o = cause_q;

endmodule : plw_top

// *** tb/plw_monitor.sv ***
// port-level assertion checker for the program loop watchdog
`timescale 1ns/1ps
module plw_monitor
  import plw_pkg::*;
(
  // clock, reset and controls
  input wire logic        core_clk_i, rst_n_i, ce_i, opt_slow_fixed_i, cause_clr_i,
  // register port
  input wire logic [15:0] bus_addr_i,
  input wire logic        bus_wr_i, bus_rd_i, bus_bitop_i, bus_wait_o,
  input wire logic [7:0]  bus_wdata_i, bus_rdata_o,
  // reset outputs
  input wire logic        watchdog_reset_cause_flag_o, wdt_reset_o
);
  wire  mw = ce_i && bus_wr_i && bus_addr_i == PLW_MODE_ADDR;
  wire  rw = ce_i && bus_wr_i && bus_addr_i == PLW_REFRESH_ADDR;
  logic seen_q;
  logic stop_q;
  // tracks the write-once phase; a trip restarts it like a system reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      seen_q <= 1'h0;
      stop_q <= 1'h0;
    end else if (mw && (!seen_q || wdt_reset_o)) begin
      seen_q <= 1'h1;
      stop_q <= bus_wdata_i[PLW_CSEL_HI_BIT] && !opt_slow_fixed_i;
    end else if (wdt_reset_o) begin
      seen_q <= 1'h0;
      stop_q <= 1'h0;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_WAIT_SET: assert property (mw |=> bus_wait_o)
    else $error("no wait after mode write");
  AST_WAIT_ONE: assert property (ce_i && !mw |=> !bus_wait_o)
    else $error("wait without mode write");
  AST_RD_KEY: assert property (ce_i && bus_rd_i && bus_addr_i == PLW_REFRESH_ADDR |=> bus_rdata_o == 8'h9A)
    else $error("refresh register read wrong");
  AST_BAD_KEY: assert property (rw && !stop_q && (bus_bitop_i || bus_wdata_i != 8'hAC) |=> wdt_reset_o)
    else $error("bad refresh did not trip");
  AST_SECOND_MODE: assert property (mw && seen_q && !stop_q && !wdt_reset_o |=> wdt_reset_o)
    else $error("second mode write did not trip");
  AST_STOPPED_QUIET: assert property (stop_q |=> !wdt_reset_o)
    else $error("trip while stopped");
  AST_FLAG_SET: assert property (wdt_reset_o |-> watchdog_reset_cause_flag_o)
    else $error("trip without cause flag");
  AST_PULSE: assert property ($rose(wdt_reset_o) |=> !wdt_reset_o)
    else $error("reset pulse too long");
  AST_FLAG_HOLD: assert property (watchdog_reset_cause_flag_o && ce_i && !cause_clr_i |=> watchdog_reset_cause_flag_o)
    else $error("cause flag lost");
endmodule : plw_monitor

bind plw_top plw_monitor u_mon (.*);

// *** tb/program_loop_watchdog_test.sv ***
// self-checking testbench for the program loop watchdog
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module program_loop_watchdog_test;
  import plw_pkg::*;
  logic        core_clk_i = '0, rst_n_i = '0, ce_i = '1, opt_slow_fixed_i = '0, cause_clr_i = '0;
  logic        bus_wr_i = '0, bus_rd_i = '0, bus_bitop_i = '0, slow_osc_frequency_i = '0;
  logic        main_osc_input_i = '0, halt_i = '0, stop_i = '0, main_osc_stopped_i = '0;
  logic        osc_stab_i = '0, cpu_on_main_i = '0, slow_osc_stopped_i = '0, rd_pend = '0, wt_pend = '0;
  logic        bus_wait_o, watchdog_reset_cause_flag_o, wdt_reset_o;
  logic [15:0] bus_addr_i = '0;
  logic [7:0]  bus_wdata_i = '0, bus_rdata_o, v, ev;
  logic [7:0]  exp_q[$];
  int          miscompares = 0, cmp_count = 0, trips = 0, t0;

  plw_top dut_u (.*);

  initial forever #2 core_clk_i = ~core_clk_i;

  // result watcher: read data one cycle after the strobe, trips counted
  always @(posedge core_clk_i) begin
    if (wdt_reset_o) trips++;
    if (rst_n_i) `CHK(bus_wait_o, wt_pend)
    if (rd_pend) begin
      ev = exp_q.pop_front();
      `CHK(bus_rdata_o, ev)
    end
    rd_pend <= bus_rd_i && ce_i;
    if (!rst_n_i) wt_pend <= 1'b0;
    else if (ce_i) wt_pend <= bus_wr_i && bus_addr_i == PLW_MODE_ADDR;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc

  // one bus access; a read leaves its expected value for the watcher
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w, input logic b);
    @(negedge core_clk_i);
    bus_addr_i = a;
    bus_wdata_i = d;
    bus_wr_i = w;
    bus_rd_i = !w;
    bus_bitop_i = b;
    if (!w) exp_q.push_back(d);
    @(negedge core_clk_i);
    bus_wr_i = '0;
    bus_rd_i = '0;
    bus_bitop_i = '0;
  endtask : acc

  // n rising edges of the slow pin, slow enough for the synchroniser
  task automatic osc(input int n);
    repeat (2 * n) begin
      cyc(4);
      slow_osc_frequency_i = ~slow_osc_frequency_i;
    end
  endtask : osc

  // n rising edges of the main pin, two cycles a phase, still seen once each
  task automatic mosc(input int n);
    repeat (2 * n) begin
      cyc(2);
      main_osc_input_i = ~main_osc_input_i;
    end
  endtask : mosc

  task automatic rst(input logic o);
    @(negedge core_clk_i);
    rst_n_i = '0;
    opt_slow_fixed_i = o;
    cyc(10);
    rst_n_i = '1;
    cyc(2);
  endtask : rst

  task automatic results();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial begin
    cyc(100000);
    miscompares++;
    results();
  end

  initial begin
    void'($urandom(51));
    rst(1'h0);
    acc(PLW_MODE_ADDR, 8'h67, 0, 0);
    acc(PLW_REFRESH_ADDR, 8'h9A, 0, 0);
    acc(16'hFF00, 8'h00, 0, 0);
    ce_i = '0; // frozen block ignores a bad refresh
    acc(PLW_REFRESH_ADDR, 8'h00, 1, 0);
    ce_i = '1;
    cyc(3);
    `CHK(trips, 0)
    $display("reset values done");
    acc(PLW_MODE_ADDR, 8'h60, 1, 0);
    acc(PLW_MODE_ADDR, 8'h60, 0, 0);
    t0 = trips;
    acc(PLW_MODE_ADDR, 8'h61, 1, 0);
    cyc(2);
    `CHK(trips - t0, 1)
    `CHK(watchdog_reset_cause_flag_o, 1'h1)
    acc(PLW_MODE_ADDR, 8'h67, 0, 0);
    cause_clr_i = '1;
    cyc(1);
    cause_clr_i = '0;
    `CHK(watchdog_reset_cause_flag_o, 1'h0)
    $display("write once done");
    v = 8'($urandom);
    if (v == 8'hAC) v = 8'h00;
    for (int i = 0; i < 3; i++) begin
      t0 = trips;
      acc(PLW_REFRESH_ADDR, i == 0 ? v : 8'hAC, 1, i == 1);
      cyc(2);
      `CHK(trips - t0, int'(i < 2))
    end
    $display("refresh key done");
    acc(PLW_MODE_ADDR, 8'h60, 1, 0); // slow source, code 0: 2048 edges
    t0 = trips;
    osc(1200);
    acc(PLW_REFRESH_ADDR, 8'hAC, 1, 0);
    halt_i = '1;
    osc(600);
    halt_i = '0;
    stop_i = '1;
    osc(600);
    stop_i = '0;
    cpu_on_main_i = '1;
    slow_osc_stopped_i = '1;
    osc(100);
    cpu_on_main_i = '0;
    slow_osc_stopped_i = '0;
    osc(1200);
    `CHK(trips - t0, 0)
    osc(900);
    cyc(12);
    `CHK(trips - t0, 1)
    $display("overflow done");
    acc(PLW_MODE_ADDR, 8'h68, 1, 0); // main source, code 0: 8192 edges
    t0 = trips;
    main_osc_stopped_i = '1;
    mosc(20);
    main_osc_stopped_i = '0;
    osc_stab_i = '1;
    mosc(20);
    cyc(4);
    osc_stab_i = '0;
    mosc(8191);
    cyc(12);
    `CHK(trips - t0, 0)
    mosc(1);
    cyc(12);
    `CHK(trips - t0, 1)
    $display("main source done");
    acc(PLW_MODE_ADDR, 8'h70, 1, 0);
    t0 = trips;
    acc(PLW_MODE_ADDR, 8'h60, 1, 0);
    acc(PLW_REFRESH_ADDR, 8'h00, 1, 1);
    osc(2100);
    cyc(8);
    `CHK(trips - t0, 0)
    $display("stopped done");
    rst(1'h1);
    acc(PLW_MODE_ADDR, 8'hFB, 1, 0);
    acc(PLW_MODE_ADDR, 8'h63, 0, 0);
    t0 = trips;
    acc(PLW_REFRESH_ADDR, 8'h00, 1, 0);
    cyc(2);
    `CHK(trips - t0, 1)
    $display("fixed option done");
    results();
  end
endmodule : program_loop_watchdog_test
